// ---- design/bnvp_pkg.sv ----
// package of constants and types for the bytewide nv ram port controller
// Behaviour
// RQ1 - memory captures 15-bit address at select falling edge
// RQ2 - memory ignores address changes after select falls until next fall
// RQ3 - memory uses 8-bit bidirectional bus, undriven while output enable high
// RQ4 - output enable only gates data drivers, not cycle type
// RQ5 - controller makes a fresh select falling edge for every cycle
// RQ6 - memory completes the full internal cycle once started
// RQ7 - read data valid only 70 ns after select falls
// RQ8 - early output enable leaves bus undriven until data valid
// RQ9 - controller changes address only after address hold time
// RQ10 - strobe low at select fall starts a write cycle
// RQ11 - select-controlled write never has memory drive the bus
// RQ12 - strobe falling after select starts as read, then writes bus
// RQ13 - write access ends at first rising edge of strobe or select
// RQ14 - controller holds write data stable for set-up before write end
// RQ15 - read and write cycles both take 140 ns, equal access times; the controller's shortest read cycle is 200 ns, write cycle 180 ns
// RQ16 - writes finish in bus cycle, next access may follow at once
// RQ17 - select high starts precharge; each cycle is access plus precharge
// RQ18 - controller keeps select high for minimum precharge before next cycle
// RQ19 - controller never holds select low beyond maximum active time
// RQ20 - minimum precharge with select high is 70 ns
// RQ21 - select low at least 70 ns, at most 2000 ns per cycle
// RQ22 - memory idles, bus undriven, no array access while select high
package bnvp_pkg;
  localparam int ADDR_W      = 15;
  localparam int DATA_W      = 8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACCESS_NS = 70;   // select low to data valid, also min low
  localparam int T_PRECH_NS  = 70;   // minimum select high
  localparam int T_CYCLE_NS  = 140;
  localparam int T_AHOLD_NS  = 15;   // address hold after select fall
  localparam int T_DSETUP_NS = 40;   // data set-up before write end
  localparam int T_WPULSE_NS = 40;   // write strobe pulse width
  localparam int T_CAMAX_NS  = 2000; // maximum select low
  // least times round up, longest time rounds down
  localparam int ACC_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_CYC   = (T_PRECH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC  = (T_AHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC    = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC    = (T_DSETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAMAX_CYC = T_CAMAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W     = 8;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

  // request from the user side
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bnvp_req_t;

  // memory pins driven by the controller
  typedef struct packed {
    logic              sel_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] byte_location_in;
  } bnvp_pins_t;

  typedef enum logic [2:0] {
    BNVP_IDLE   = 3'b000,
    BNVP_ACCESS = 3'b001,
    BNVP_WRITE  = 3'b010,
    BNVP_PRECH  = 3'b011
  } bnvp_state_t;

  // cycles the select must stay low: access time plus one cycle for a read, or strobe window for a write
  function automatic logic [CNT_W-1:0] bnvp_low_cycles(input logic wr);
    int n;
    n = wr ? ((WP_CYC > DS_CYC ? WP_CYC : DS_CYC) + HOLD_CYC) : ACC_CYC + 1;
    if (n < ACC_CYC) n = ACC_CYC;
    if (n > CAMAX_CYC) n = CAMAX_CYC;
    return n[CNT_W-1:0];
  endfunction : bnvp_low_cycles
endpackage : bnvp_pkg

// ---- design/bnvp_ctrl.sv ----
// controller driving a bytewide nv ram port from a simple request port
`timescale 1ns/1ps
module bnvp_ctrl
  import bnvp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              req_valid,
  input  wire bnvp_req_t         req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output bnvp_pins_t             pins,
  output logic [DATA_W-1:0]      byte_bus_out,
  output logic                   byte_bus_oe,
  input  wire logic [DATA_W-1:0] byte_bus_in
);
  bnvp_state_t       state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              wr_r, wr_nxt;
  logic              ready_r, ready_nxt;
  logic              rv_r, rv_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  bnvp_pins_t        pins_r, pins_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              doe_r, doe_nxt;

  // next-state logic of the access sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = wr_r;
    ready_nxt = ready_r;
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    pins_nxt  = pins_r;
    dout_nxt  = dout_r;
    doe_nxt   = doe_r;
    case (state_r)
      BNVP_IDLE: begin
        if (req_valid && ready_r) begin
          // new cycle always begins with a fresh select fall
          pins_nxt.sel_n = 1'b0;                         // RQ5
          pins_nxt.byte_location_in = req.addr;          // RQ1
          wr_nxt    = req.wr;
          ready_nxt = 1'b0;
          // select-controlled write: strobe low in the same cycle select falls
          pins_nxt.we_n = ~req.wr;                       // RQ10
          pins_nxt.oe_n = req.wr;                        // RQ4
          dout_nxt  = req.wdata;                         // RQ14
          doe_nxt   = req.wr;                            // RQ11
          cnt_nxt   = bnvp_low_cycles(req.wr);           // RQ21
          state_nxt = BNVP_ACCESS;
        end
      end
      BNVP_ACCESS: begin
        // address held on pins through the whole low phase
        if (cnt_r > 8'h01) begin                          // RQ9
          cnt_nxt = cnt_r - 8'h01;                        // RQ19
        end else begin
          // select and strobe rise together, ending write access
          pins_nxt.sel_n = 1'b1;                          // RQ13
          pins_nxt.we_n  = 1'b1;
          pins_nxt.oe_n  = 1'b1;
          if (!wr_r) begin
            rd_nxt = byte_bus_in;                         // RQ7
            rv_nxt = 1'b1;
          end
          cnt_nxt   = PRE_CYC[CNT_W-1:0];                 // RQ18
          state_nxt = BNVP_PRECH;
        end
      end
      BNVP_PRECH: begin
        // keep driving write data one cycle past select rise (hold)
        doe_nxt = 1'b0;                                   // RQ22
        if (cnt_r > 8'h01) begin
          cnt_nxt = cnt_r - 8'h01;                        // RQ20
        end else begin
          ready_nxt = 1'b1;                               // RQ15 RQ16
          state_nxt = BNVP_IDLE;                          // RQ17
        end
      end
      default: begin
        state_nxt = BNVP_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  // registers of the sequencer and pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= BNVP_IDLE;
      cnt_r   <= '0;
      wr_r    <= 1'b0;
      ready_r <= 1'b1;
      rv_r    <= 1'b0;
      rd_r    <= DATA_RST;
      pins_r  <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                   byte_location_in: ADDR_RST};
      dout_r  <= DATA_RST;
      doe_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      ready_r <= ready_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      pins_r  <= pins_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
    end
  end

  // outputs straight from flip-flops
  assign req_ready    = ready_r;
  assign rsp_valid    = rv_r;
  assign rsp_rdata    = rd_r;
  assign pins         = pins_r;
  assign byte_bus_out = dout_r;
  assign byte_bus_oe  = doe_r;                            // RQ3
endmodule : bnvp_ctrl

// ---- tb/bnvp_chk_sva.sv ----
// checker for the controller side of the memory port
`timescale 1ns/1ps
module bnvp_chk
  import bnvp_pkg::*;
(
  input logic              sys_clk,
  input logic              reset_n,
  input logic              req_valid,
  input logic              req_ready,
  input logic              rsp_valid,
  input bnvp_pins_t        pins,
  input logic [DATA_W-1:0] byte_bus_out,
  input logic              byte_bus_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // select fall and rise steps of a cycle
  sequence s_fall; $fell(pins.sel_n); endsequence
  sequence s_rise; $rose(pins.sel_n); endsequence
  start_on_req_a: assert property (s_fall |-> $past(req_valid && req_ready))
    else $error("select fell without a request");
  low_min_a: assert property (s_fall |-> !pins.sel_n [*4])
    else $error("select low too short");
  low_max_a: assert property (s_fall |-> ##[1:100] pins.sel_n)
    else $error("select low too long");
  prech_min_a: assert property (s_rise |-> pins.sel_n [*4])
    else $error("precharge too short");
  addr_hold_a: assert property (!pins.sel_n && $past(!pins.sel_n)
    |-> $stable(pins.byte_location_in)) else $error("address moved");
  data_setup_a: assert property (!pins.we_n && $past(!pins.we_n)
    |-> byte_bus_oe && $stable(byte_bus_out)) else $error("data moved");
  cycle_time_a: assert property (s_fall |=> (!$fell(pins.sel_n)) [*6])
    else $error("cycle too short");
  read_done_a: assert property (s_fall ##0 !pins.oe_n |-> ##5 rsp_valid)
    else $error("read answer late");
  bus_clash_a: assert property (byte_bus_oe |-> pins.oe_n)
    else $error("bus driven while output enabled");
endmodule : bnvp_chk

bind bnvp_ctrl bnvp_chk u_chk (.*);

// ---- tb/bnvp_mem.sv ----
// behavioural model of the bytewide memory
`timescale 1ns/1ps
module bnvp_mem
  import bnvp_pkg::*;
(
  input  bnvp_pins_t  pins,
  input  logic [7:0]  bus,
  output logic [7:0]  q,
  output logic        oe
);
  logic [7:0]  arr [0:32767];
  logic [14:0] a;
  logic        wr = 0, act = 0, vld = 0;
  // cycle start latches address and type
  always @(negedge pins.sel_n) begin
    a = pins.byte_location_in;
    wr = !pins.we_n;
    act = 1;
    vld = 0;
    vld <= #70 1;
  end
  // late strobe turns a read into a write
  always @(negedge pins.we_n) if (act) wr = 1;
  // write ends at first rise, select rise precharges
  always @(posedge pins.we_n or posedge pins.sel_n) begin
    if (act && wr) arr[a] = bus;
    wr = 0;
    if (pins.sel_n) act = 0;
  end
  // drive only valid read data
  assign oe = act && !wr && vld && !pins.oe_n;
  assign q = arr[a];
endmodule : bnvp_mem

// ---- tb/bnvp_ctrl_tb.sv ----
// testbench for the bytewide memory port controller
`timescale 1ns/1ps
module bnvp_ctrl_tb;
  import bnvp_pkg::*;
  logic sys_clk = 0, reset_n = 0, req_valid = 0;
  logic req_ready, rsp_valid, bus_oe, m_oe;
  logic [7:0] rdata, bus_out, m_q, bus, flt = 8'h5a;
  bnvp_req_t req = '0;
  bnvp_pins_t pins;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  // clock, floating bus pattern and timeout
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    flt <= ~flt;
    if (++cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  // bus level from every driver
  assign bus = bus_oe ? bus_out : m_oe ? m_q : flt;
  bnvp_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rdata), .pins(pins), .byte_bus_out(bus_out),
    .byte_bus_oe(bus_oe), .byte_bus_in(bus));
  bnvp_mem u_mem (.pins(pins), .bus(bus), .q(m_q), .oe(m_oe));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task op(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    #1 req_valid = 1;
    req = '{w, a, d};
    // ready looked at once settled; the edge after it takes the request
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1 req_valid = 0;
    n = 0;
    if (!w) begin
      do begin @(posedge sys_clk); #1 n++; end while (rsp_valid !== 1 && n < 9);
      chk(rsp_valid, 1);
      chk(rdata, d);
    end
  endtask : op
  task t_boundary;
    op(1, 15'h0000, 8'ha5);
    op(1, 15'h7fff, 8'h3c);
    op(0, 15'h0000, 8'ha5);
    op(0, 15'h7fff, 8'h3c);
    $display("boundary test done");
  endtask : t_boundary
  task t_overwrite;
    op(1, 15'h1234, 8'h11);
    op(0, 15'h1234, 8'h11);
    op(1, 15'h1234, 8'hee);
    op(0, 15'h1234, 8'hee);
    $display("overwrite test done");
  endtask : t_overwrite
  task t_reset;
    @(posedge sys_clk);
    #1 req_valid = 1;
    req = '{1'b1, 15'h0042, 8'h77};
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 0;
    req_valid = 0;
    #1 chk(pins.sel_n, 1);
    chk(req_ready, 1);
    chk(pins.we_n, 1);
    chk(bus_oe, 0);
    // cut cycle still needs a full precharge before the next select fall
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1;
    op(0, 15'h0000, 8'ha5);
    $display("reset test done");
  endtask : t_reset
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1;
    t_boundary;
    t_overwrite;
    t_reset;
    close_out;
  end
endmodule : bnvp_ctrl_tb
